// ==== hw/oscsc_regs.svh ====
`ifndef OSCSC_REGS_SVH
`define OSCSC_REGS_SVH

// register byte offsets
`define OSCSC_OFS_OSC 12'h004
`define OSCSC_OFS_STANDBY 12'h008
`define OSCSC_OFS_PLL 12'h00c
`define OSCSC_OFS_CKSEL 12'h010

// oscillator_control fields
`define OSCSC_OSC_RSV_HI 13
`define OSCSC_OSC_RSV_LO 12
`define OSCSC_OSC_LSEN 9
`define OSCSC_OSC_HSEN 8
`define OSCSC_OSC_WUPT_HI 6
`define OSCSC_OSC_WUPT_LO 4
`define OSCSC_OSC_WUPSEL 3
`define OSCSC_OSC_PLLRUN 2
`define OSCSC_OSC_BUSY 1
`define OSCSC_OSC_START 0

// standby_control fields
`define OSCSC_STANDBY_RSV 17
`define OSCSC_STANDBY_DRIVE 16
`define OSCSC_STANDBY_LSRST 9
`define OSCSC_STANDBY_HSRST 8
`define OSCSC_STANDBY_MODE_HI 2
`define OSCSC_STANDBY_MODE_LO 0

// pll_source_select and system_clock_select fields
`define OSCSC_PLL_SEL 0
`define OSCSC_CK_SEL 1
`define OSCSC_CK_FLAG 0

// reset values
`define OSCSC_RST_OSCEN 1'h1
`define OSCSC_RST_WUPT 3'h1
`define OSCSC_RST_HSRST 1'h1
`define OSCSC_RST_LSRST 1'h0
`define OSCSC_RST_MODE 3'h3

// warm-up exponent offsets and pll ratio
`define OSCSC_HS_EXP_OFS 5'h09
`define OSCSC_LS_EXP_LOW_OFS 5'h05
`define OSCSC_LS_EXP_HIGH_OFS 5'h0b
`define OSCSC_PLL_MULT 3'h4
`define OSCSC_DIRECT_MULT 3'h1

`endif

// ==== hw/oscsc_pkg.sv ====
package oscsc_pkg;

  typedef enum logic [2:0] {
    OSCSC_LPM_STOP = 3'h1,
    OSCSC_LPM_SLEEP = 3'h2,
    OSCSC_LPM_IDLE = 3'h3
  } oscsc_lpm_t;

  typedef enum logic [4:0] {
    OSCSC_NORMAL = 5'h01,
    OSCSC_IDLE = 5'h02,
    OSCSC_SLEEP = 5'h04,
    OSCSC_STOP = 5'h08,
    OSCSC_WARM = 5'h10
  } oscsc_mode_t;

endpackage

// ==== hw/oscsc_wup_if.sv ====
`timescale 1ns/1ps
interface oscsc_wup_if;
  logic start;
  logic sel;
  logic [2:0] code;
  logic hsCrystal;
  logic lsCrystal;
  logic busy;
  logic done;

  modport ctrl (output start, output sel, output code, output hsCrystal, output lsCrystal,
    input busy, input done);
  modport timer (input start, input sel, input code, input hsCrystal, input lsCrystal,
    output busy, output done);
endinterface

// ==== hw/oscsc_wup_timer.sv ====
`timescale 1ns/1ps
`include "oscsc_regs.svh"
module oscsc_wup_timer import oscsc_pkg::*; #(
  parameter int CNT_W = 18
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control side
  oscsc_wup_if.timer wup
);

  if (CNT_W < 18) begin : g_chk
    $error("warm-up counter needs at least 18 bits");
  end

  // 0 means no warm-up, otherwise log2 of the count
  function automatic logic [4:0] warmExponent(input logic sel, input logic [2:0] code);
    logic [4:0] e;
    e = 5'h00;
    if (code != 3'h0) begin
      if (!sel) begin
        e = `OSCSC_HS_EXP_OFS + {2'h0, code};
      end else if (!code[2]) begin
        e = `OSCSC_LS_EXP_LOW_OFS + {2'h0, code};
      end else begin
        e = `OSCSC_LS_EXP_HIGH_OFS + {2'h0, code};
      end
    end
    return e;
  endfunction

  logic hsPrev;
  logic lsPrev;
  logic selReg;
  logic busy;
  logic done;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  wire [4:0] expo = warmExponent(wup.sel, wup.code);
  wire [CNT_W-1:0] next_limit = ~({CNT_W{1'b1}} << expo);
  wire hsEdge = wup.hsCrystal & ~hsPrev;
  wire lsEdge = wup.lsCrystal & ~lsPrev;
  // selection latched at start so a later write cannot switch sources mid-count
  wire tick = selReg ? lsEdge : hsEdge;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsPrev <= 1'b0;
      lsPrev <= 1'b0;
      selReg <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
      limit <= '0;
    end else begin
      hsPrev <= wup.hsCrystal;
      lsPrev <= wup.lsCrystal;
      done <= 1'b0;
      if (wup.start) begin
        selReg <= wup.sel;
        cnt <= '0;
        limit <= next_limit;
        busy <= (expo != 5'h00);
        done <= (expo == 5'h00);
      end else if (busy && tick) begin
        if (cnt == limit) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  assign wup.busy = busy;
  assign wup.done = done;

endmodule

// ==== hw/oscsc_ctrl.sv ====
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - warm-up source bit picks counting oscillator
// - high-speed codes: none, then 2^10..2^16
// - low-speed codes: none, 2^6..2^8, 2^15..2^18
// - pll run bit, cleared by reset
// - busy bit reads 1 while counting
// - writing 1 starts warm-up; 0 ignored
// - pin drive bit 16 for stop, resets 0
// - low-speed restart bit 9, resets 0
// - high-speed restart bit 8, resets 1
// - mode field: stop, sleep, idle; resets 011
// - pll source select, resets to direct
// - clock status follows select after delay
// - wake from stop/sleep runs warm-up first
// - pll path is four times crystal
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "oscsc_regs.svh"
module oscsc_ctrl import oscsc_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int SWITCH_CYCLES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal inputs, sampled as levels
  input wire logic highSpeedCrystalInput,
  input wire logic lowSpeedCrystalInput,
  // low-power handshake with the core
  input wire logic standbyRequest,
  input wire logic wakeInterrupt,
  // clock tree controls
  output logic highSpeedOscRun,
  output logic lowSpeedOscRun,
  output logic pllRun,
  output logic pllSourceSelect,
  output logic [2:0] highSpeedRatio,
  output logic systemClockLow,
  output logic systemClockState,
  output logic cpuClockRun,
  output logic standbyPinDrive,
  output logic [4:0] lowPowerState
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk_addr
    $error("address width must cover the register map");
  end
  if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) begin : g_chk_sw
    $error("switch delay must be 1 to 255 cycles");
  end

  localparam logic [7:0] SW_LAST = 8'(SWITCH_CYCLES - 1);

  function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return {a[ADDR_W-1:2], 2'h0} == ADDR_W'(ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic hsEn;
  logic lsEn;
  logic pll_run_enable;
  logic wupSel;
  logic [2:0] wupCode;
  logic [1:0] oscRsv;
  logic standbyRsv;
  logic pinDrive;
  logic lsRestart;
  logic hsRestart;
  logic [2:0] lpmCode;
  logic pllSel;
  logic sysClkSel;
  logic sysClkFlag;
  logic [7:0] swCnt;
  logic startReg;
  oscsc_mode_t mode;
  oscsc_mode_t next_mode;

  oscsc_wup_if wup ();

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrEn = accessDone & pwrite;
  wire hitOsc = addrHit(paddr, `OSCSC_OFS_OSC);
  wire hitStandby = addrHit(paddr, `OSCSC_OFS_STANDBY);
  wire hitPll = addrHit(paddr, `OSCSC_OFS_PLL);
  wire hitCk = addrHit(paddr, `OSCSC_OFS_CKSEL);
  wire mapped = hitOsc | hitStandby | hitPll | hitCk;
  wire wrOsc = wrEn & hitOsc;
  wire wrStandby = wrEn & hitStandby;
  wire wrPll = wrEn & hitPll;
  wire wrCk = wrEn & hitCk;

  logic [31:0] rdOsc;
  logic [31:0] rdStandby;
  logic [31:0] rdPll;
  logic [31:0] rdCk;
  logic [31:0] rdSel;

  // unused and write-only positions stay zero; the start bit always reads 0
  always_comb begin
    rdOsc = 32'h0000_0000;
    rdOsc[`OSCSC_OSC_RSV_HI:`OSCSC_OSC_RSV_LO] = oscRsv;
    rdOsc[`OSCSC_OSC_LSEN] = lsEn;
    rdOsc[`OSCSC_OSC_HSEN] = hsEn;
    rdOsc[`OSCSC_OSC_WUPT_HI:`OSCSC_OSC_WUPT_LO] = wupCode;
    rdOsc[`OSCSC_OSC_WUPSEL] = wupSel;
    rdOsc[`OSCSC_OSC_PLLRUN] = pll_run_enable;
    rdOsc[`OSCSC_OSC_BUSY] = wup.busy;
    rdStandby = 32'h0000_0000;
    rdStandby[`OSCSC_STANDBY_RSV] = standbyRsv;
    rdStandby[`OSCSC_STANDBY_DRIVE] = pinDrive;
    rdStandby[`OSCSC_STANDBY_LSRST] = lsRestart;
    rdStandby[`OSCSC_STANDBY_HSRST] = hsRestart;
    rdStandby[`OSCSC_STANDBY_MODE_HI:`OSCSC_STANDBY_MODE_LO] = lpmCode;
    rdPll = 32'h0000_0000;
    rdPll[`OSCSC_PLL_SEL] = pllSel;
    rdCk = 32'h0000_0000;
    rdCk[`OSCSC_CK_SEL] = sysClkSel;
    rdCk[`OSCSC_CK_FLAG] = sysClkFlag;
  end

  assign rdSel = hitOsc ? rdOsc :
                 hitStandby ? rdStandby :
                 hitPll ? rdPll :
                 hitCk ? rdCk : 32'h0000_0000;

  // answer is prepared in the setup cycle so that every bus output is a flop;
  // the price is one fixed wait-free access with data sampled one cycle early
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      prdata <= (setupPhase && !pwrite) ? rdSel : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-power sequencing

  wire wakeFromStop = (mode == OSCSC_STOP) & wakeInterrupt;
  wire wakeToWarm = ((mode == OSCSC_STOP) | (mode == OSCSC_SLEEP)) & wakeInterrupt;
  // a done pulse left over from an earlier count must not end this warm-up
  wire warmDone = (mode == OSCSC_WARM) & wup.done & ~startReg;

  always_comb begin
    next_mode = mode;
    case (mode)
      OSCSC_NORMAL: begin
        if (standbyRequest) begin
          case (lpmCode)
            OSCSC_LPM_STOP: next_mode = OSCSC_STOP;
            OSCSC_LPM_SLEEP: next_mode = OSCSC_SLEEP;
            OSCSC_LPM_IDLE: next_mode = OSCSC_IDLE;
            default: next_mode = OSCSC_NORMAL;
          endcase
        end
      end
      OSCSC_IDLE: begin
        if (wakeInterrupt) begin
          next_mode = OSCSC_NORMAL;
        end
      end
      OSCSC_SLEEP: begin
        if (wakeInterrupt) begin
          next_mode = OSCSC_WARM;
        end
      end
      OSCSC_STOP: begin
        if (wakeInterrupt) begin
          next_mode = OSCSC_WARM;
        end
      end
      OSCSC_WARM: begin
        if (warmDone) begin
          next_mode = OSCSC_NORMAL;
        end
      end
      default: next_mode = OSCSC_NORMAL;
    endcase
  end

  wire next_start = (wrOsc & pwdata[`OSCSC_OSC_START]) | wakeToWarm;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= OSCSC_NORMAL;
      startReg <= 1'b0;
    end else begin
      mode <= next_mode;
      startReg <= next_start;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator_control

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsEn <= `OSCSC_RST_OSCEN;
      lsEn <= `OSCSC_RST_OSCEN;
      pll_run_enable <= 1'b0;
      wupSel <= 1'b0;
      wupCode <= `OSCSC_RST_WUPT;
      oscRsv <= 2'h0;
    end else if (wakeFromStop) begin
      hsEn <= hsRestart;
      lsEn <= lsRestart;
    end else if (wrOsc) begin
      hsEn <= pwdata[`OSCSC_OSC_HSEN];
      lsEn <= pwdata[`OSCSC_OSC_LSEN];
      pll_run_enable <= pwdata[`OSCSC_OSC_PLLRUN];
      wupSel <= pwdata[`OSCSC_OSC_WUPSEL];
      wupCode <= pwdata[`OSCSC_OSC_WUPT_HI:`OSCSC_OSC_WUPT_LO];
      oscRsv <= pwdata[`OSCSC_OSC_RSV_HI:`OSCSC_OSC_RSV_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // standby_control and pll_source_select

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standbyRsv <= 1'b0;
      pinDrive <= 1'b0;
      lsRestart <= `OSCSC_RST_LSRST;
      hsRestart <= `OSCSC_RST_HSRST;
      lpmCode <= `OSCSC_RST_MODE;
    end else if (wrStandby) begin
      standbyRsv <= pwdata[`OSCSC_STANDBY_RSV];
      pinDrive <= pwdata[`OSCSC_STANDBY_DRIVE];
      lsRestart <= pwdata[`OSCSC_STANDBY_LSRST];
      hsRestart <= pwdata[`OSCSC_STANDBY_HSRST];
      lpmCode <= pwdata[`OSCSC_STANDBY_MODE_HI:`OSCSC_STANDBY_MODE_LO];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pllSel <= 1'b0;
    end else if (wrPll) begin
      pllSel <= pwdata[`OSCSC_PLL_SEL];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system_clock_select: status lags the select by the switch delay

  wire switching = sysClkSel != sysClkFlag;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysClkSel <= 1'b0;
      sysClkFlag <= 1'b0;
      swCnt <= 8'h00;
    end else begin
      if (wrCk) begin
        sysClkSel <= pwdata[`OSCSC_CK_SEL];
      end
      if (switching && swCnt == SW_LAST) begin
        sysClkFlag <= sysClkSel;
        swCnt <= 8'h00;
      end else if (switching) begin
        swCnt <= swCnt + 8'h01;
      end else begin
        swCnt <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // warm-up timer

  assign wup.start = startReg;
  assign wup.sel = wupSel;
  assign wup.code = wupCode;
  assign wup.hsCrystal = highSpeedCrystalInput;
  assign wup.lsCrystal = lowSpeedCrystalInput;

  oscsc_wup_timer #(
    .CNT_W(18)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wup(wup.timer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock tree outputs, registered from the next mode so they track it exactly

  wire nextStop = next_mode == OSCSC_STOP;
  wire nextDeep = nextStop | (next_mode == OSCSC_SLEEP);
  wire next_hsEn = wakeFromStop ? hsRestart : (wrOsc ? pwdata[`OSCSC_OSC_HSEN] : hsEn);
  wire next_lsEn = wakeFromStop ? lsRestart : (wrOsc ? pwdata[`OSCSC_OSC_LSEN] : lsEn);
  wire next_pll_run_enable = wrOsc ? pwdata[`OSCSC_OSC_PLLRUN] : pll_run_enable;
  wire next_pllSel = wrPll ? pwdata[`OSCSC_PLL_SEL] : pllSel;
  wire next_pinDrive = wrStandby ? pwdata[`OSCSC_STANDBY_DRIVE] : pinDrive;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      highSpeedOscRun <= `OSCSC_RST_OSCEN;
      lowSpeedOscRun <= `OSCSC_RST_OSCEN;
      pllRun <= 1'b0;
      pllSourceSelect <= 1'b0;
      highSpeedRatio <= `OSCSC_DIRECT_MULT;
      systemClockLow <= 1'b0;
      systemClockState <= 1'b0;
      cpuClockRun <= 1'b1;
      standbyPinDrive <= 1'b1;
      lowPowerState <= OSCSC_NORMAL;
    end else begin
      highSpeedOscRun <= next_hsEn & ~nextStop;
      lowSpeedOscRun <= next_lsEn & ~nextStop;
      pllRun <= next_pll_run_enable & ~nextDeep;
      pllSourceSelect <= next_pllSel;
      highSpeedRatio <= next_pllSel ? `OSCSC_PLL_MULT : `OSCSC_DIRECT_MULT;
      systemClockLow <= sysClkSel;
      systemClockState <= sysClkFlag;
      cpuClockRun <= next_mode == OSCSC_NORMAL;
      standbyPinDrive <= ~nextStop | next_pinDrive;
      lowPowerState <= next_mode;
    end
  end

endmodule

// ==== hw/oscsc_unused_placeholder.sv ====
`timescale 1ns/1ps

// ==== test/oscsc_ctrl_sva.sv ====
`timescale 1ns/1ps
module oscsc_ctrl_sva import oscsc_pkg::*; #(
  parameter int SWITCH_CYCLES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and clock tree
  input wire logic wakeInterrupt,
  input wire logic highSpeedOscRun,
  input wire logic lowSpeedOscRun,
  input wire logic pllRun,
  input wire logic pllSourceSelect,
  input wire logic [2:0] highSpeedRatio,
  input wire logic systemClockLow,
  input wire logic systemClockState,
  input wire logic cpuClockRun,
  input wire logic standbyPinDrive,
  input wire logic [4:0] lowPowerState
);
  // status may trail the select by the switch delay plus one edge
  localparam int SW_MAX = SWITCH_CYCLES + 1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////
  property p_ratio;
    highSpeedRatio == (pllSourceSelect ? 3'h4 : 3'h1);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio does not follow pll select");
  property p_pllOff;
    $rose(rst_n) |-> !pllRun && !pllSourceSelect;
  endproperty
  a_pllOff: assert property (p_pllOff) else $error("pll active after reset");
  property p_cpu;
    cpuClockRun == (lowPowerState == OSCSC_NORMAL);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock outside normal mode");
  property p_wake;
    wakeInterrupt && (lowPowerState inside {OSCSC_STOP, OSCSC_SLEEP}) |=> lowPowerState == OSCSC_WARM;
  endproperty
  a_wake: assert property (p_wake) else $error("wake skipped warm-up");
  property p_pin;
    !standbyPinDrive |-> lowPowerState == OSCSC_STOP;
  endproperty
  a_pin: assert property (p_pin) else $error("pins idle outside stop");
  property p_stop;
    lowPowerState == OSCSC_STOP |-> !(highSpeedOscRun || lowSpeedOscRun || pllRun);
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator running in stop");
  property p_switch;
    $changed(systemClockLow) |-> (systemClockState != systemClockLow) ##[1:SW_MAX]
      (systemClockState == systemClockLow);
  endproperty
  a_switch: assert property (p_switch) else $error("clock status did not lag then follow");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  c_warm: cover property (lowPowerState == OSCSC_WARM);
  c_err: cover property (pslverr);
  c_switch: cover property ($changed(systemClockState));
endmodule

bind oscsc_ctrl oscsc_ctrl_sva #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_sva (.sys_clk, .rst_n, .prdata, .pready,
  .pslverr, .wakeInterrupt, .highSpeedOscRun, .lowSpeedOscRun, .pllRun, .pllSourceSelect, .highSpeedRatio,
  .systemClockLow, .systemClockState, .cpuClockRun, .standbyPinDrive, .lowPowerState);

// ==== test/oscsc_ctrl_tb.sv ====
`timescale 1ns/1ps
module oscsc_ctrl_tb import oscsc_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic highSpeedCrystalInput = 1'b0, lowSpeedCrystalInput = 1'b0;
  logic standbyRequest = 1'b0, wakeInterrupt = 1'b0;
  logic [31:0] prdata, rdq;
  logic pready, pslverr, rde, highSpeedOscRun, lowSpeedOscRun, pllRun, pllSourceSelect;
  logic systemClockLow, systemClockState, cpuClockRun, standbyPinDrive;
  logic [2:0] highSpeedRatio;
  logic [4:0] lowPowerState;
  int cyc = 0, checks = 0, errTotal = 0;
  // bit 3 picks the low-speed crystal, bits 2:0 the warm-up code
  logic [3:0] wc [6] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'hb, 4'hc};

  oscsc_ctrl #(.SWITCH_CYCLES(4)) dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .highSpeedCrystalInput, .lowSpeedCrystalInput, .standbyRequest, .wakeInterrupt,
    .highSpeedOscRun, .lowSpeedOscRun, .pllRun, .pllSourceSelect, .highSpeedRatio, .systemClockLow,
    .systemClockState, .cpuClockRun, .standbyPinDrive, .lowPowerState);

  always #20 sys_clk = ~sys_clk;
  // crystals at half the bus clock keep the long warm-up counts short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    highSpeedCrystalInput <= ~highSpeedCrystalInput;
    lowSpeedCrystalInput <= ~lowSpeedCrystalInput;
  end
  //////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bad(input string m);
    errTotal++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      bad($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad("no bus answer");
      finish_test();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask
  task automatic st(input oscsc_mode_t m);
    chk({27'h0, lowPowerState}, {27'h0, m});
  endtask
  task automatic pulse(input logic w);
    if (w)
      wakeInterrupt <= 1'b1;
    else
      standbyRequest <= 1'b1;
    @(posedge sys_clk);
    wakeInterrupt <= 1'b0;
    standbyRequest <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic waitRun;
    int k = 0;
    while (lowPowerState !== OSCSC_NORMAL && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    st(OSCSC_NORMAL);
    if (k >= 2000)
      finish_test();
  endtask
  task automatic warm(input logic s, input logic [2:0] c);
    int n, t0, k;
    n = c == 3'h0 ? 0 : (!s ? c + 9 : (c < 3'h4 ? c + 5 : c + 11));
    k = 0;
    wr(12'h004, {22'h0, 2'b11, 1'b0, c, s, 3'b001});
    t0 = cyc;
    @(posedge sys_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rdq[1]}, {31'h0, n != 0});
    while (rdq[1] === 1'b1 && k < 30000) begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
    end
    if (rdq[1] !== 1'b0) begin
      bad("warm-up never ends");
      finish_test();
    end
    if (n != 0)
      chk({31'h0, (cyc - t0) inside {[(2 << n) - 8 : (2 << n) + 16]}}, 32'h1);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(12'h004, 32'h310);
    rdc(12'h008, 32'h103);
    rdc(12'h00c, 32'h0);
    rdc(12'h010, 32'h0);
    wr(12'h000, 32'hffffffff);
    rdc(12'h000, 32'h0);
    chk({31'h0, rde}, 32'h1);
    wr(12'h004, 32'hfffffffe);
    rdc(12'h004, 32'h337c);
    chk({31'h0, pllRun}, 32'h1);
    wr(12'h008, 32'hffffffff);
    rdc(12'h008, 32'h30307);
    wr(12'h00c, 32'hffffffff);
    rdc(12'h00c, 32'h1);
    chk({29'h0, highSpeedRatio}, 32'h4);
    wr(12'h010, 32'hffffffff);
    rdc(12'h010, 32'h2);
    repeat (8) @(posedge sys_clk);
    rdc(12'h010, 32'h3);
    chk({30'h0, systemClockLow, systemClockState}, 32'h3);
    wr(12'h010, 32'h0);
    for (int i = 0; i < 6; i++)
      warm(wc[i][3], wc[i][2:0]);
    wr(12'h004, 32'h31c);
    rdc(12'h004, 32'h31c);
    wr(12'h008, 32'h100);
    pulse(1'b0);
    st(OSCSC_NORMAL);
    wr(12'h008, 32'h103);
    pulse(1'b0);
    st(OSCSC_IDLE);
    pulse(1'b1);
    st(OSCSC_NORMAL);
    wr(12'h008, 32'h102);
    pulse(1'b0);
    st(OSCSC_SLEEP);
    chk({31'h0, pllRun}, 32'h0);
    chk({31'h0, cpuClockRun}, 32'h0);
    pulse(1'b1);
    st(OSCSC_WARM);
    waitRun();
    wr(12'h008, 32'h101);
    pulse(1'b0);
    st(OSCSC_STOP);
    chk({31'h0, standbyPinDrive}, 32'h0);
    pulse(1'b1);
    waitRun();
    rdc(12'h004, 32'h11c);
    chk({30'h0, lowSpeedOscRun, highSpeedOscRun}, 32'h1);
    wr(12'h008, 32'h10301);
    pulse(1'b0);
    chk({31'h0, standbyPinDrive}, 32'h1);
    pulse(1'b1);
    waitRun();
    rdc(12'h004, 32'h31c);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(12'h00c, 32'h0);
    wr(12'h00c, 32'h1);
    rdc(12'h00c, 32'h1);
    chk({29'h0, highSpeedRatio}, 32'h4);
    finish_test();
  end
endmodule
